// >>> design/ecl_pkg.sv
package ecl_pkg;
    localparam int          CLK_HZ    = 25_000_000;
    localparam int          SCL_HZ    = 80_000;
    // Quarter of an SCL period, rounded up so the bus never runs fast
    localparam int          QTR_CYC   = (CLK_HZ + SCL_HZ * 4 - 1) / (SCL_HZ * 4);
    localparam logic [6:0]  QTR_LAST  = 7'(QTR_CYC - 1);
    localparam logic [6:0]  EE_DEV    = 7'H50;
    localparam logic [2:0]  EE_BLK    = 3'H0;
    localparam logic [6:0]  SLV_DEV   = 7'H55;
    localparam logic [7:0]  EE_START  = 8'H00;
    localparam logic [6:0]  RUN_ADDR  = 7'H02;
    localparam int          RUN_BIT   = 7;
    localparam logic [6:0]  SLEN_ADDR = 7'H17;
    localparam int          SLEN_BIT  = 3;
    localparam logic [6:0]  CRC_ADDR  = 7'H1F;
    localparam logic [6:0]  REL_ADDR  = 7'H2F;
    localparam logic [6:0]  CFG_BYTES = 7'H40;
    localparam logic [5:0]  LAST_BYTE = 6'H3F;
    localparam logic [8:0]  CRC_POLY  = 9'H11D;
    localparam logic [7:0]  CRC_INIT  = 8'H01;
    localparam logic [3:0]  CRC_BITS  = 4'H8;
    localparam logic [1:0]  LAST_TRY  = 2'H3;
    localparam int          BYTE_W    = 8;
    localparam int          FIFO_D    = 32;

    typedef enum logic [2:0] {
        M_BOOT  = 3'H0,
        M_START = 3'H1,
        M_TX    = 3'H2,
        M_RX    = 3'H3,
        M_STOP  = 3'H4,
        M_WAIT  = 3'H5,
        M_OK    = 3'H6,
        M_FAIL  = 3'H7
    } ecl_mst_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'H0,
        S_ADDR = 3'H1,
        S_REG  = 3'H2,
        S_WDAT = 3'H3,
        S_RDAT = 3'H4
    } ecl_slv_t;

    typedef struct packed {
        logic cfg_valid;
        logic slave_on;
        logic gave_up;
    } ecl_stat_t;

    function automatic logic [7:0] ecl_crc_step(input logic [7:0] crc, input logic d);
        ecl_crc_step = (crc[7] != d) ? ({crc[6:0], 1'B0} ^ CRC_POLY[7:0]) : {crc[6:0], 1'B0};
    endfunction : ecl_crc_step
endpackage : ecl_pkg

// >>> design/ecl_loader.sv
// Notes on behaviour
// - Line driver stays off after reset until a valid EEPROM configuration at 0x50 or a slave write of run-enable one.
// - A checksum mismatch repeats the whole read-in from the start.
// - After the fourth failed attempt the EEPROM is left alone, slave mode on.
// - With a valid load, the loaded slave-enable bit decides slave mode.
// - Byte 0x1F is compared with the CRC over bytes 0x00 to 0x1E.
// - CRC-8 poly 0x11D, start 0x01, bit-serial, MSB first.
// - Addresses 0x00 to 0x3F are read, so 64 bytes are needed.
// - Slave answers 0x55; EEPROM block selects stay within 0x50 to 0x57.
// - In slave mode, address 0x55 gives read and write access to registers.
// - Address 0x2F returns a fixed release code and ignores writes.
// - Writing run-enable zero puts converter and driver in standby.
// - Writing run-enable one restarts conversion and enables the driver.
// - Run-enable acts on a valid load and on slave writes; reading it shows the stored byte.
// - EEPROM bytes use an 8-bit address plus three block-select bits.
`timescale 1ns/1ps

module ecl_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;

    assign in_ready  = cnt != (AW+1)'(D);
    assign out_valid = cnt != '0;
    assign out_data  = mem[rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            wp  <= push ? AW'(wp + 1'B1) : wp;
            rp  <= pop ? AW'(rp + 1'B1) : rp;
            cnt <= (AW+1)'(cnt + push - pop);
        end
    end
endmodule : ecl_fifo

module ecl_loader #(
    parameter logic [7:0] REL_CODE = 8'H5A  // Arbitrary release code
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    output logic             CONV_EN,
    output logic             DRV_EN,
    output ecl_pkg::ecl_stat_t STATUS
);
    logic               rst_q1, rst_n;
    logic               scl_q1, scl_s, scl_d;
    logic               sda_q1, sda_s, sda_d;
    logic [7:0]         ram [64];
    ecl_pkg::ecl_mst_t  mst;
    logic [6:0]         qcnt;
    logic [1:0]         q;
    logic [3:0]         bi;
    logic [1:0]         seq;
    logic [1:0]         tries;
    logic [5:0]         rx_n;
    logic [7:0]         tx, rx;
    logic               nak, m_scl_lo, m_sda_lo;
    logic               tick, rx_end, adv, stop_end;
    logic               f_in_ready, f_out_valid, fire;
    logic [7:0]         f_dout;
    logic [6:0]         d_cnt;
    logic [7:0]         crc, cb;
    logic [3:0]         crc_left;
    logic               chk_done, crc_ok, attempt_bad, retry, load_ok;
    logic               cfg_valid, slave_on, gave_up, run;
    ecl_pkg::ecl_slv_t  s_st;
    logic [3:0]         s_cnt;
    logic [7:0]         s_sh, s_tx, rd_byte;
    logic [6:0]         s_ptr;
    logic               s_sda_lo, s_rise, s_fall, s_start, s_stop, s_wr, s_wr_ok;

    // Reset release and pin synchronisers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_q1 <= 1'B0;
            rst_n  <= 1'B0;
        end else begin
            rst_q1 <= 1'B1;
            rst_n  <= rst_q1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            {scl_q1, scl_s, scl_d} <= 3'H7;
            {sda_q1, sda_s, sda_d} <= 3'H7;
        end else begin
            {scl_q1, scl_s, scl_d} <= {SCL_I, scl_q1, scl_s};
            {sda_q1, sda_s, sda_d} <= {SDA_I, sda_q1, sda_s};
        end
    end

    assign s_rise  = scl_s && !scl_d;
    assign s_fall  = !scl_s && scl_d;
    assign s_start = scl_s && scl_d && !sda_s && sda_d;
    assign s_stop  = scl_s && scl_d && sda_s && !sda_d;

    // Master bit timing; a full FIFO holds the byte end and stalls SCL
    assign tick     = qcnt == ecl_pkg::QTR_LAST;
    assign rx_end   = mst == ecl_pkg::M_RX && bi == 4'H8 && q == 2'H3;
    assign adv      = tick && !(rx_end && !f_in_ready);
    assign stop_end = mst == ecl_pkg::M_STOP && adv && q == 2'H3;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            qcnt <= '0;
        end else begin
            qcnt <= tick ? 7'H00 : 7'(qcnt + 1'B1);
        end
    end

    // Checksum verdict
    assign chk_done    = d_cnt == ecl_pkg::CFG_BYTES && crc_left == 4'H0;
    assign crc_ok      = crc == ram[ecl_pkg::CRC_ADDR[5:0]];
    assign load_ok     = mst == ecl_pkg::M_WAIT && chk_done && crc_ok;
    assign attempt_bad = (stop_end && nak)
                       || (mst == ecl_pkg::M_WAIT && chk_done && !crc_ok);
    assign retry       = attempt_bad && tries != ecl_pkg::LAST_TRY;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            mst      <= ecl_pkg::M_BOOT;
            q        <= '0;
            bi       <= '0;
            seq      <= '0;
            tries    <= '0;
            rx_n     <= '0;
            tx       <= '0;
            rx       <= '0;
            nak      <= 1'B0;
            m_scl_lo <= 1'B0;
            m_sda_lo <= 1'B0;
        end else if (attempt_bad) begin
            tries    <= 2'(tries + 1'B1);
            nak      <= 1'B0;
            m_scl_lo <= 1'B0;
            m_sda_lo <= 1'B0;
            mst      <= retry ? ecl_pkg::M_BOOT : ecl_pkg::M_FAIL;
        end else if (adv) begin
            q <= 2'(q + 1'B1);
            unique case (mst)
                ecl_pkg::M_BOOT: begin
                    if (q == 2'H3) begin
                        mst  <= ecl_pkg::M_START;
                        seq  <= 2'H0;
                        rx_n <= '0;
                    end
                end
                ecl_pkg::M_START: begin
                    unique case (q)
                        2'H0: m_sda_lo <= 1'B0;
                        2'H1: m_scl_lo <= 1'B0;
                        2'H2: m_sda_lo <= 1'B1;
                        2'H3: begin
                            m_scl_lo <= 1'B1;
                            mst      <= ecl_pkg::M_TX;
                            bi       <= '0;
                            // Device byte: base id plus block select
                            tx <= {ecl_pkg::EE_DEV[6:3], ecl_pkg::EE_BLK, seq == 2'H2};
                        end
                    endcase
                end
                ecl_pkg::M_TX, ecl_pkg::M_RX: begin
                    unique case (q)
                        2'H0: begin
                            if (mst == ecl_pkg::M_TX) begin
                                m_sda_lo <= bi < 4'H8 && !tx[7];
                            end else begin
                                m_sda_lo <= bi == 4'H8 && rx_n != ecl_pkg::LAST_BYTE;
                            end
                        end
                        2'H1: m_scl_lo <= 1'B0;
                        2'H2: begin
                            if (bi < 4'H8) begin
                                rx <= {rx[6:0], sda_s};
                            end else if (mst == ecl_pkg::M_TX) begin
                                nak <= sda_s;
                            end
                        end
                        2'H3: begin
                            m_scl_lo <= 1'B1;
                            bi       <= 4'(bi + 1'B1);
                            if (bi < 4'H8) begin
                                tx <= {tx[6:0], 1'B0};
                            end else if (mst == ecl_pkg::M_RX) begin
                                bi   <= '0;
                                rx_n <= 6'(rx_n + 1'B1);
                                if (rx_n == ecl_pkg::LAST_BYTE) begin
                                    mst <= ecl_pkg::M_STOP;
                                end
                            end else if (nak) begin
                                mst <= ecl_pkg::M_STOP;
                            end else begin
                                bi <= '0;
                                unique case (seq)
                                    2'H0: begin
                                        tx  <= ecl_pkg::EE_START;
                                        seq <= 2'H1;
                                    end
                                    2'H1: begin
                                        mst <= ecl_pkg::M_START;
                                        seq <= 2'H2;
                                    end
                                    default: mst <= ecl_pkg::M_RX;
                                endcase
                            end
                        end
                    endcase
                end
                ecl_pkg::M_STOP: begin
                    unique case (q)
                        2'H0: m_sda_lo <= 1'B1;
                        2'H1: m_scl_lo <= 1'B0;
                        2'H2: m_sda_lo <= 1'B0;
                        2'H3: mst <= ecl_pkg::M_WAIT;
                    endcase
                end
                ecl_pkg::M_WAIT: begin
                    if (load_ok) begin
                        mst <= ecl_pkg::M_OK;
                    end
                end
                ecl_pkg::M_OK, ecl_pkg::M_FAIL: mst <= mst;
            endcase
        end else if (load_ok) begin
            mst <= ecl_pkg::M_OK;
        end
    end

    ecl_fifo #(.W(ecl_pkg::BYTE_W), .D(ecl_pkg::FIFO_D)) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (rst_n),
        .in_valid  (tick && rx_end),
        .in_data   (rx),
        .in_ready  (f_in_ready),
        .out_valid (f_out_valid),
        .out_data  (f_dout),
        .out_ready (crc_left == 4'H0)
    );

    // Drain: store bytes in order and feed the CRC one bit per cycle
    assign fire = f_out_valid && crc_left == 4'H0;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            d_cnt    <= '0;
            crc      <= ecl_pkg::CRC_INIT;
            cb       <= '0;
            crc_left <= '0;
        end else if (retry) begin
            d_cnt    <= '0;
            crc      <= ecl_pkg::CRC_INIT;
            crc_left <= '0;
        end else if (crc_left != 4'H0) begin
            crc      <= ecl_pkg::ecl_crc_step(crc, cb[7]);
            cb       <= {cb[6:0], 1'B0};
            crc_left <= 4'(crc_left - 1'B1);
        end else if (fire) begin
            d_cnt <= 7'(d_cnt + 1'B1);
            if (d_cnt < ecl_pkg::CRC_ADDR) begin
                cb       <= f_dout;
                crc_left <= ecl_pkg::CRC_BITS;
            end
        end
    end

    assign s_wr    = s_fall && s_cnt == 4'H7 && s_st == ecl_pkg::S_WDAT;
    assign s_wr_ok = s_wr && s_ptr < ecl_pkg::CFG_BYTES && s_ptr != ecl_pkg::REL_ADDR;
    assign rd_byte = s_ptr == ecl_pkg::REL_ADDR ? REL_CODE
                   : s_ptr < ecl_pkg::CFG_BYTES ? ram[s_ptr[5:0]] : 8'H00;

    always_ff @(posedge CLK_SYS) begin
        if (fire) begin
            ram[d_cnt[5:0]] <= f_dout;
        end else if (s_wr_ok) begin
            ram[s_ptr[5:0]] <= s_sh;
        end
    end

    // Mode and run control
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            cfg_valid <= 1'B0;
            slave_on  <= 1'B0;
            gave_up   <= 1'B0;
            run       <= 1'B0;
        end else if (load_ok) begin
            cfg_valid <= 1'B1;
            slave_on  <= ram[ecl_pkg::SLEN_ADDR[5:0]][ecl_pkg::SLEN_BIT];
            run       <= ram[ecl_pkg::RUN_ADDR[5:0]][ecl_pkg::RUN_BIT];
        end else if (attempt_bad && !retry) begin
            slave_on <= 1'B1;
            gave_up  <= 1'B1;
        end else if (s_wr_ok && s_ptr == ecl_pkg::RUN_ADDR) begin
            run <= s_sh[ecl_pkg::RUN_BIT];
            if (s_sh[ecl_pkg::RUN_BIT]) begin
                cfg_valid <= 1'B1;
            end
        end
    end

    // Slave engine on synchronised SCL edges
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            s_st     <= ecl_pkg::S_IDLE;
            s_cnt    <= '0;
            s_sh     <= '0;
            s_tx     <= '0;
            s_ptr    <= '0;
            s_sda_lo <= 1'B0;
        end else if (!slave_on || s_stop) begin
            s_st     <= ecl_pkg::S_IDLE;
            s_sda_lo <= 1'B0;
        end else if (s_start) begin
            s_st     <= ecl_pkg::S_ADDR;
            s_cnt    <= 4'H8;  // The SCL fall after START ends no bit
            s_sda_lo <= 1'B0;
        end else if (s_rise) begin
            if (s_cnt < 4'H8) begin
                s_sh <= {s_sh[6:0], sda_s};
            end else if (s_st == ecl_pkg::S_RDAT && sda_s) begin
                s_st <= ecl_pkg::S_IDLE;
            end
        end else if (s_fall && s_st != ecl_pkg::S_IDLE) begin
            s_cnt <= s_cnt == 4'H8 ? 4'H0 : 4'(s_cnt + 1'B1);
            if (s_cnt == 4'H7) begin
                s_sda_lo <= s_st != ecl_pkg::S_RDAT;
                unique case (s_st)
                    ecl_pkg::S_ADDR: begin
                        if (s_sh[7:1] == ecl_pkg::SLV_DEV) begin
                            s_st <= s_sh[0] ? ecl_pkg::S_RDAT : ecl_pkg::S_REG;
                        end else begin
                            s_st     <= ecl_pkg::S_IDLE;
                            s_sda_lo <= 1'B0;
                        end
                    end
                    ecl_pkg::S_REG: begin
                        s_ptr <= s_sh[6:0];
                        s_st  <= ecl_pkg::S_WDAT;
                    end
                    ecl_pkg::S_WDAT: s_ptr <= 7'(s_ptr + 1'B1);
                    default: s_ptr <= 7'(s_ptr + 1'B1);
                endcase
            end else if (s_cnt == 4'H8 && s_st == ecl_pkg::S_RDAT) begin
                s_tx     <= {rd_byte[6:0], 1'B0};
                s_sda_lo <= !rd_byte[7];
            end else if (s_cnt == 4'H8) begin
                s_sda_lo <= 1'B0;
            end else if (s_st == ecl_pkg::S_RDAT) begin
                s_tx     <= {s_tx[6:0], 1'B0};
                s_sda_lo <= !s_tx[7];
            end
        end
    end

    // Registered outputs; SCL and SDA are open drain
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            SCL_O   <= 1'B0;
            SDA_O   <= 1'B0;
            SCL_OE  <= 1'B0;
            SDA_OE  <= 1'B0;
            CONV_EN <= 1'B0;
            DRV_EN  <= 1'B0;
            STATUS  <= '0;
        end else begin
            SCL_O   <= 1'B0;
            SDA_O   <= 1'B0;
            SCL_OE  <= m_scl_lo;
            SDA_OE  <= m_sda_lo || s_sda_lo;
            CONV_EN <= cfg_valid && run;
            DRV_EN  <= cfg_valid && run;
            STATUS  <= '{cfg_valid: cfg_valid, slave_on: slave_on, gave_up: gave_up};
        end
    end

    default clocking cb_sys @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    hiz_until_valid_a: assert property (!cfg_valid |=> !DRV_EN && !CONV_EN)
        else $error("driver enabled without valid configuration");
    retry_reload_a: assert property (retry |=> d_cnt == 7'H00 && crc == ecl_pkg::CRC_INIT
        && mst == ecl_pkg::M_BOOT)
        else $error("retry did not restart the read-in");
    giveup_slave_a: assert property (attempt_bad && tries == ecl_pkg::LAST_TRY
        |=> slave_on && mst == ecl_pkg::M_FAIL)
        else $error("fourth failure did not enable slave mode");
    fail_quiet_a: assert property (mst == ecl_pkg::M_FAIL |=> !m_scl_lo && !m_sda_lo)
        else $error("master still drives bus after giving up");
    slave_from_cfg_a: assert property (load_ok
        |=> slave_on == $past(ram[ecl_pkg::SLEN_ADDR[5:0]][ecl_pkg::SLEN_BIT]))
        else $error("slave enable not taken from loaded byte");
    crc_serial_a: assert property (fire && d_cnt < ecl_pkg::CRC_ADDR
        |=> crc_left == 4'H8 ##8 crc_left == 4'H0)
        else $error("CRC byte not shifted in eight cycles");
    byte_range_a: assert property (fire |-> d_cnt < ecl_pkg::CFG_BYTES)
        else $error("configuration byte beyond 0x3F");
    rel_read_a: assert property (slave_on && s_st == ecl_pkg::S_RDAT && s_fall
        && s_cnt == 4'H8 && s_ptr == ecl_pkg::REL_ADDR
        |=> s_tx == {REL_CODE[6:0], 1'B0} && s_sda_lo == !REL_CODE[7])
        else $error("release code not returned");
    run_write_a: assert property (s_wr_ok && s_ptr == ecl_pkg::RUN_ADDR
        |=> run == $past(s_sh[7]) ##1 DRV_EN == (cfg_valid && $past(run)))
        else $error("run enable write not applied");
    addr_match_a: assert property (s_st == ecl_pkg::S_ADDR && s_fall && s_cnt == 4'H7
        && s_sh[7:1] != ecl_pkg::SLV_DEV |=> s_st == ecl_pkg::S_IDLE)
        else $error("slave answered a foreign address");

    load_ok_c: cover property (load_ok);
    give_up_c: cover property (attempt_bad && !retry);
    fifo_stall_c: cover property (rx_end && !f_in_ready);
    slave_run_c: cover property (s_wr_ok && s_ptr == ecl_pkg::RUN_ADDR);
endmodule : ecl_loader

// >>> tb/ecl_eeprom_mdl.sv
`timescale 1ns/1ps
module ecl_eeprom_mdl (
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_oe
);
    logic [7:0] mem [64];  // Read-only model; written bytes only set the pointer
    logic [7:0] sh;
    logic [7:0] cur;
    logic [3:0] n;
    logic [5:0] ptr;
    logic       act;
    logic       rd;
    logic       first;
    int         tries;
    int         bad_tries;  // Attempts that see a corrupted checksum byte
    int         ack_tries;  // Attempts whose address is acknowledged
    initial begin
        sda_oe = 1'B0;
        act = 1'B0;
        tries = 0;
        ptr = 6'H00;
    end
    always @(negedge sda) if (scl) begin
        act = 1'B1;
        first = 1'B1;
        rd = 1'B0;
        n = 4'H8;  // START's own SCL fall ends no bit
        sda_oe = 1'B0;
    end
    always @(posedge sda) if (scl) act = 1'B0;
    always @(posedge scl) if (act) begin
        if (n == 4'H8) act = !(rd && sda);
        else sh = {sh[6:0], sda};
    end
    always @(negedge scl) if (act) begin
        sda_oe = 1'B0;
        if (n == 4'H8) begin
            n = 4'H0;
            if (rd) begin
                cur = mem[ptr] ^ {7'H00, ptr == 6'H1F && tries <= bad_tries};
                ptr = ptr + 6'H01;
                sda_oe = ~cur[7];
            end
        end else begin
            n = n + 4'H1;
            if (n == 4'H8 && first) begin
                tries = tries + int'(sh == 8'HA0);
                act = (sh[7:1] == 7'H50) && tries <= ack_tries;
                rd = sh[0];
                first = 1'B0;
                sda_oe = act;
            end else if (n == 4'H8 && !rd) begin
                ptr = sh[5:0];
                sda_oe = 1'B1;
            end else if (rd && n != 4'H8) sda_oe = ~cur[7 - n];
        end
    end
endmodule : ecl_eeprom_mdl

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] REL = 8'H3C;  // Arbitrary release code
    logic clk_sys;
    logic rst_n;
    logic m_scl;
    logic m_sda;
    logic scl_oe;
    logic sda_oe;
    logic e_sda;
    logic conv_en;
    logic drv_en;
    logic scl_o;
    logic sda_o;
    logic ack;
    logic [7:0] rx;
    ecl_pkg::ecl_stat_t status;
    wire  scl = ~(scl_oe | m_scl);
    wire  sda = ~(sda_oe | e_sda | m_sda);
    int   err_count = 0;
    int   total_checks = 0;
    int   cyc = 0;
    ecl_loader #(.REL_CODE(REL)) dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .SCL_I(scl),
        .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .CONV_EN(conv_en), .DRV_EN(drv_en), .STATUS(status));
    ecl_eeprom_mdl mdl (.scl(scl), .sda(sda), .sda_oe(e_sda));
    task automatic hold(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : hold
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic complete_run();
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic sbit(input logic b, output logic got);
        m_sda <= ~b;
        hold(40);
        m_scl <= 1'B0;
        hold(40);
        got = sda;
        m_scl <= 1'B1;
        hold(40);
    endtask : sbit
    task automatic sbyte(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) sbit(d[i], q[i]);
        sbit(1'B1, ack);
    endtask : sbyte
    task automatic bus_start();
        m_sda <= 1'B0;
        hold(40);
        m_scl <= 1'B0;
        hold(40);
        m_sda <= 1'B1;
        hold(40);
        m_scl <= 1'B1;
        hold(40);
    endtask : bus_start
    task automatic bus_stop();
        m_sda <= 1'B1;
        hold(40);
        m_scl <= 1'B0;
        hold(40);
        m_sda <= 1'B0;
        hold(40);
    endtask : bus_stop
    task automatic slv_write(input logic [7:0] a, input logic [7:0] d);
        bus_start();
        sbyte(8'HAA, rx);
        chk("slave address ack", 8'H00, {7'H00, ack});
        sbyte(a, rx);
        sbyte(d, rx);
        chk("slave data ack", 8'H00, {7'H00, ack});
        bus_stop();
    endtask : slv_write
    task automatic slv_read(input logic [7:0] a, output logic [7:0] q);
        bus_start();
        sbyte(8'HAA, rx);
        sbyte(a, rx);
        bus_start();
        sbyte(8'HAB, rx);
        sbyte(8'HFF, q);
        bus_stop();
    endtask : slv_read
    task automatic do_reset(input int bad, input int acked);
        logic [7:0] c;
        for (int a = 0; a < 64; a++) mdl.mem[a] = 8'(a * 37 + 5);
        mdl.mem[2] = mdl.mem[2] | 8'H80;
        mdl.mem[23] = mdl.mem[23] & 8'HF7;
        c = 8'H01;
        for (int a = 0; a < 31; a++) for (int b = 7; b >= 0; b--)
            c = (c[7] != mdl.mem[a][b]) ? ({c[6:0], 1'B0} ^ 8'H1D) : {c[6:0], 1'B0};
        mdl.mem[31] = c;
        mdl.tries = 0;
        mdl.bad_tries = bad;
        mdl.ack_tries = acked;
        rst_n <= 1'B0;
        hold(10);
        rst_n <= 1'B1;
    endtask : do_reset
    task automatic wait_end();
        while (status.cfg_valid !== 1'B1 && status.gave_up !== 1'B1) hold(1);
        hold(2);
    endtask : wait_end
    initial begin
        clk_sys = 1'B0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 600_000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        rst_n = 1'B0;
        m_scl = 1'B0;
        m_sda = 1'B0;
        do_reset(1, 4);
        hold(5000);
        chk("enables while loading", 8'H00, {6'H00, drv_en, conv_en});
        wait_end();
        chk("good load status", 8'H04, {5'H00, status});
        chk("good load attempts", 8'H02, 8'(mdl.tries));
        chk("good load enables", 8'H03, {6'H00, drv_en, conv_en});
        do_reset(0, 0);
        wait_end();
        hold(20000);
        chk("bad load status", 8'H03, {5'H00, status});
        chk("bad load attempts", 8'H04, 8'(mdl.tries));
        chk("enables after give-up", 8'H00, {6'H00, drv_en, conv_en});
        chk("open drain levels", 8'H00, {6'H00, scl_o, sda_o});
        slv_write(8'H02, 8'H80);
        hold(4);
        chk("enables after run write", 8'H03, {6'H00, drv_en, conv_en});
        slv_write(8'H2F, 8'H00);
        slv_read(8'H2F, rx);
        chk("release code", REL, rx);
        slv_read(8'H02, rx);
        chk("run control readback", 8'H80, rx);
        slv_write(8'H02, 8'H00);
        hold(4);
        chk("enables in standby", 8'H00, {6'H00, drv_en, conv_en});
        complete_run();
    end
endmodule : tb
